// ### hw/dbt_pkg.sv
// constants for the burst, termination and command timing block
// assumes all counts are in link clock (CK) cycles unless named otherwise
package dbt_pkg;
   // sampled pin vector positions
   localparam int P_CK   = 0;
   localparam int P_CKE  = 1;
   localparam int P_ODT  = 2;
   localparam int P_CS   = 3;
   localparam int P_RAS  = 4;
   localparam int P_CAS  = 5;
   localparam int P_WE   = 6;
   localparam int P_A12  = 7;
   localparam int P_AP   = 8;
   localparam int P_ALO  = 9;
   localparam int PIN_W  = 12;
   // burst field of the mode register
   localparam logic [1:0] BURST_FIX8 = 2'h0;
   localparam logic [1:0] BURST_OTF  = 2'h1;
   // data clocks per burst, in CK cycles
   localparam logic [2:0] BEATS_BC4  = 3'h2;
   localparam logic [2:0] BEATS_BL8  = 3'h4;
   // half the column-to-column delay and the extra read-to-write turnaround clocks
   localparam logic [7:0] TCCD_HALF  = 8'h02;
   localparam logic [7:0] TURN_EXTRA = 8'h02;
   // termination hold after write
   localparam logic [3:0] ODTH4      = 4'h4;
   localparam logic [3:0] ODTH8      = 4'h6;
   localparam logic [3:0] HOLD_MAX   = 4'hF;
   localparam logic [5:0] ONE6       = 6'h01;
endpackage

// ### hw/dbt_core.sv
// device-side command timing: burst decode, latency, dynamic termination,
// write recovery, read-to-write check after chopped reads and power-down termination mode
// assumes CK_I and all command pins are asynchronous to CLK_I and much slower
// Operation
// - OTF field with A12 low gives BC4
// - fixed field, or OTF with A12 high: BL8
// - write latency is AL plus CWL
// - write recovery taken from mode register
`timescale 1ns/10ps
module dbt_core (
   input  wire logic                   CLK_I,
   input  wire logic                   RST_I,
   input  wire logic                   CK_I,
   input  wire logic                   CKE_I,
   input  wire logic                   ODT_I,
   input  wire logic                   CS_N_I,
   input  wire logic                   RAS_N_I,
   input  wire logic                   CAS_N_I,
   input  wire logic                   WE_N_I,
   input  wire logic                   A12_I,
   input  wire logic                   AP_I,
   input  wire logic [2:0]             ALO_I,
   input  wire logic [1:0]             BURST_MODE_I,
   input  wire logic [4:0]             CL_I,
   input  wire logic [4:0]             CWL_I,
   input  wire logic [4:0]             AL_I,
   input  wire logic [4:0]             WR_I,
   input  wire logic                   MPR_EN_I,
   input  wire logic                   DLL_FROZEN_I,
   input  wire logic                   ERR_CLR_I,
   output logic                        BC4_O,
   output logic [5:0]                  WL_O,
   output logic [5:0]                  RL_O,
   output logic                        RX_O,
   output logic                        RTT_WR_O,
   output logic                        RTT_NOM_O,
   output logic                        WR_REC_O,
   output logic                        ODT_TRANS_O,
   output logic                        ODT_ASYNC_O,
   output logic                        ODT_HOLD_ERR_O,
   output logic                        TURN_ERR_O,
   output logic                        MPR_ERR_O
);
   import dbt_pkg::*;

   typedef struct packed {
      logic [PIN_W-1:0] pin_m;
      logic [PIN_W-1:0] pin_s;
      logic             ck_d;
      logic             cke_d;
      logic             odt_d;
      logic [5:0]       wl;
      logic [5:0]       rl;
      logic             bc4;
      logic             wr_bc4;
      logic             wr_ap;
      logic [5:0]       wr_wait;
      logic [2:0]       beats;
      logic [4:0]       wr_rec;
      logic [3:0]       odt_hold;
      logic             dyn;
      logic             dyn_bc4;
      logic [5:0]       rd_gap;
      logic [5:0]       anpd;
      logic             async;
      logic             rtt_wr;
      logic             rtt_nom;
      logic             rx;
      logic             rec_on;
      logic             trans;
      logic             hold_err;
      logic             turn_err;
      logic             mpr_err;
   } dbt_state_type;

   dbt_state_type r_reg;
   dbt_state_type r_next;

   logic       rise;
   logic       cmd_wr;
   logic       cmd_rd;
   logic       odt;
   logic       cke;
   logic       bc4_cmd;
   logic [7:0] turn;
   logic [3:0] hold_need;

   always_comb begin
      r_next = r_reg;
      // clear first, so an error found in the same cycle still sets its flag
      if (ERR_CLR_I) begin
         r_next.hold_err = 1'b0;
         r_next.turn_err = 1'b0;
         r_next.mpr_err  = 1'b0;
      end
      r_next.pin_m = {ALO_I, AP_I, A12_I, WE_N_I, CAS_N_I, RAS_N_I, CS_N_I,
                      ODT_I, CKE_I, CK_I};
      r_next.pin_s = r_reg.pin_m;
      r_next.ck_d = r_reg.pin_s[P_CK];
      rise = r_reg.pin_s[P_CK] & ~r_reg.ck_d;
      odt = r_reg.pin_s[P_ODT];
      cke = r_reg.pin_s[P_CKE];
      // any other command in gaps is simply decoded and ignored here
      cmd_wr = ~r_reg.pin_s[P_CS] & r_reg.pin_s[P_RAS] & ~r_reg.pin_s[P_CAS]
               & ~r_reg.pin_s[P_WE];
      cmd_rd = ~r_reg.pin_s[P_CS] & r_reg.pin_s[P_RAS] & ~r_reg.pin_s[P_CAS]
               & r_reg.pin_s[P_WE];
      bc4_cmd = (BURST_MODE_I == BURST_OTF) & ~r_reg.pin_s[P_A12];
      r_next.wl = {1'b0, AL_I} + {1'b0, CWL_I};
      r_next.rl = {1'b0, AL_I} + {1'b0, CL_I};
      turn = {2'h0, r_reg.rl} + TCCD_HALF + TURN_EXTRA;
      hold_need = r_reg.dyn_bc4 ? ODTH4 : ODTH8;
      if (rise) begin
         r_next.odt_d = odt;
         r_next.cke_d = cke;
         if (cmd_wr | cmd_rd) begin
            r_next.bc4 = bc4_cmd;
         end
         // write data window and recovery
         if (cmd_wr) begin
            r_next.wr_wait = r_reg.wl;
            r_next.wr_bc4 = bc4_cmd;
            r_next.wr_ap = r_reg.pin_s[P_AP];
         end else if (r_reg.wr_wait != 6'h00) begin
            r_next.wr_wait = r_reg.wr_wait - ONE6;
            if (r_reg.wr_wait == ONE6) begin
               r_next.beats = r_reg.wr_bc4 ? BEATS_BC4 : BEATS_BL8;
            end
         end else if (r_reg.beats != 3'h0) begin
            r_next.beats = r_reg.beats - 3'h1;
            if (r_reg.beats == 3'h1 && r_reg.wr_ap) begin
               r_next.wr_rec = WR_I;
            end
         end else if (r_reg.wr_rec != 5'h00) begin
            r_next.wr_rec = r_reg.wr_rec - 5'h01;
         end
         // termination hold, counted from ODT high and from the write
         if ((odt & ~r_reg.odt_d) | (cmd_wr & odt)) begin
            r_next.odt_hold = 4'h1;
         end else if (odt && r_reg.odt_hold != HOLD_MAX) begin
            r_next.odt_hold = r_reg.odt_hold + 4'h1;
         end
         if (cmd_wr & odt) begin
            r_next.dyn = 1'b1;
            r_next.dyn_bc4 = bc4_cmd;
         end else if (~odt) begin
            r_next.dyn = 1'b0;
         end
         if (~odt & r_reg.odt_d & r_reg.dyn & (r_reg.odt_hold < hold_need)) begin
            r_next.hold_err = 1'b1;
         end
         // read-to-write spacing after a chopped read
         if (cmd_rd & bc4_cmd) begin
            r_next.rd_gap = (turn > {2'h0, r_reg.wl}) ?
                            6'(turn - {2'h0, r_reg.wl}) : 6'h00;
         end else if (r_reg.rd_gap != 6'h00) begin
            r_next.rd_gap = r_reg.rd_gap - ONE6;
         end
         if (cmd_wr && r_reg.rd_gap > ONE6) begin
            r_next.turn_err = 1'b1;
         end
         if (cmd_rd & MPR_EN_I & ((r_reg.pin_s[P_ALO +: 3] != 3'h0) | bc4_cmd)) begin
            r_next.mpr_err = 1'b1;
         end
         // termination timing change on precharge power-down entry
         if (cke) begin
            r_next.anpd = 6'h00;
            r_next.async = 1'b0;
         end else if (r_reg.cke_d & DLL_FROZEN_I) begin
            r_next.anpd = r_reg.wl - ONE6;
            r_next.async = (r_reg.wl <= ONE6);
         end else if (r_reg.anpd != 6'h00) begin
            r_next.anpd = r_reg.anpd - ONE6;
            r_next.async = (r_reg.anpd == ONE6);
         end
      end
      // write value only while write data arrives, nominal otherwise
      r_next.rtt_wr = r_next.odt_d & (r_next.beats != 3'h0);
      r_next.rtt_nom = r_next.odt_d & (r_next.beats == 3'h0);
      // status decodes are registered so every output leaves a flip-flop
      r_next.rx = r_next.beats != 3'h0;
      r_next.rec_on = r_next.wr_rec != 5'h00;
      r_next.trans = r_next.anpd != 6'h00;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign BC4_O          = r_reg.bc4;
   assign WL_O           = r_reg.wl;
   assign RL_O           = r_reg.rl;
   assign RX_O           = r_reg.rx;
   assign RTT_WR_O       = r_reg.rtt_wr;
   assign RTT_NOM_O      = r_reg.rtt_nom;
   assign WR_REC_O       = r_reg.rec_on;
   assign ODT_TRANS_O    = r_reg.trans;
   assign ODT_ASYNC_O    = r_reg.async;
   assign ODT_HOLD_ERR_O = r_reg.hold_err;
   assign TURN_ERR_O     = r_reg.turn_err;
   assign MPR_ERR_O      = r_reg.mpr_err;

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   chk_wl_sum: assert property (!RST_I |=> WL_O == 6'($past(AL_I)) + 6'($past(CWL_I)))
      else $error("write latency is not AL plus CWL");
   chk_bc4_decode: assert property (rise && (cmd_wr || cmd_rd)
      && BURST_MODE_I == BURST_OTF && !r_reg.pin_s[P_A12] |=> BC4_O)
      else $error("chopped burst not decoded");
   chk_bl8_decode: assert property (rise && (cmd_wr || cmd_rd)
      && (BURST_MODE_I == BURST_FIX8 || r_reg.pin_s[P_A12]) |=> !BC4_O)
      else $error("eight-beat burst not decoded");
   chk_turn_flag: assert property (rise && cmd_wr && r_reg.rd_gap > ONE6
      |=> TURN_ERR_O)
      else $error("early write after chopped read not flagged");
   chk_hold_short: assert property (rise && !odt && r_reg.odt_d && r_reg.dyn
      && r_reg.dyn_bc4 && r_reg.odt_hold < ODTH4 |=> ODT_HOLD_ERR_O)
      else $error("short BC4 termination hold not flagged");
   chk_hold_ok: assert property (rise && !odt && r_reg.odt_d && r_reg.dyn
      && !r_reg.dyn_bc4 && r_reg.odt_hold >= ODTH8 && !ODT_HOLD_ERR_O
      |=> !ODT_HOLD_ERR_O)
      else $error("legal BL8 termination hold flagged");
   chk_anpd_len: assert property (rise && !cke && r_reg.cke_d && DLL_FROZEN_I
      && r_reg.wl > ONE6 |=> r_reg.anpd == $past(r_reg.wl) - ONE6 && !ODT_ASYNC_O)
      else $error("power-down transition length wrong");
   chk_rec_load: assert property (rise && r_reg.wr_wait == 6'h00
      && r_reg.beats == 3'h1 && r_reg.wr_ap && WR_I != 5'h00 |=> WR_REC_O)
      else $error("write recovery not started");
   chk_rtt_wr: assert property (RTT_WR_O |-> RX_O && !RTT_NOM_O)
      else $error("write termination outside write data");
   chk_mpr_flag: assert property (rise && cmd_rd && MPR_EN_I
      && r_reg.pin_s[P_ALO +: 3] != 3'h0 |=> MPR_ERR_O)
      else $error("bad pattern read address not flagged");
endmodule

// ### bench/dbt_ctl_model.sv
// controller-side pin driver: link clock, command pins, termination, clock enable
// assumes go is called at a CLK_I rising edge, once per link clock period
`timescale 1ns/10ps
module dbt_ctl_model (
   input  wire logic       CLK_I,
   output logic            CK_O,
   output logic            CKE_O,
   output logic            ODT_O,
   output logic [3:0]      CMD_N_O,
   output logic            A12_O,
   output logic            AP_O,
   output logic [2:0]      ALO_O
);
   initial begin
      {CK_O, CKE_O, ODT_O, CMD_N_O, A12_O, AP_O, ALO_O} = {3'h2, 4'hF, 5'h10};
   end
   // pins move while CK is low and hold across the rise; column bits, burst select,
   // spacing and termination length are the caller's, so faults are deliberate
   task automatic go(input logic [3:0] c, input logic a12, input logic [2:0] alo,
                     input logic ap, input logic odt, input logic cke);
      {CK_O, CKE_O, ODT_O, CMD_N_O, A12_O, AP_O, ALO_O} <= {1'b0, cke, odt, c, a12, ap, alo};
      repeat (2) @(posedge CLK_I);
      CK_O <= 1'b1;
      repeat (6) @(posedge CLK_I);
   endtask
endmodule

// ### bench/ddr3_burst_odt_command_timing_tb.sv
// self-checking bench for the burst, termination and command timing block
// assumes the controller model drives the link pins, one command per CK period
`timescale 1ns/10ps
module ddr3_burst_odt_command_timing_tb;
   import dbt_pkg::*;
   localparam logic [3:0] CMD_WR = 4'h4, CMD_RD = 4'h5, NOP = 4'h7, DES = 4'hF;
   logic       clk = 1'b0, rst = 1'b1, mpr_en = 1'b0, dll_frz = 1'b0, err_clr = 1'b0;
   logic [1:0] burst = BURST_FIX8;
   logic [4:0] cl = 5'h05, cwl = 5'h05, al = 5'h00, wr = 5'h04;
   wire        ck, cke, odt, a12, ap, bc4, rx, rtt_wr, rtt_nom, wr_rec;
   wire        trans, async_o, odt_err, turn_err, mpr_err;
   wire [3:0]  cmd_n;
   wire [2:0]  alo;
   wire [5:0]  wl, rl;
   int         bad_count = 0, num_checks = 0, cycles = 0;
   always #50 clk = ~clk;
   dbt_ctl_model m (.CLK_I(clk), .CK_O(ck), .CKE_O(cke), .ODT_O(odt), .CMD_N_O(cmd_n),
      .A12_O(a12), .AP_O(ap), .ALO_O(alo));
   dbt_core dut (.CLK_I(clk), .RST_I(rst), .CK_I(ck), .CKE_I(cke), .ODT_I(odt),
      .CS_N_I(cmd_n[3]), .RAS_N_I(cmd_n[2]), .CAS_N_I(cmd_n[1]), .WE_N_I(cmd_n[0]),
      .A12_I(a12), .AP_I(ap), .ALO_I(alo), .BURST_MODE_I(burst), .CL_I(cl), .CWL_I(cwl),
      .AL_I(al), .WR_I(wr), .MPR_EN_I(mpr_en), .DLL_FROZEN_I(dll_frz), .ERR_CLR_I(err_clr),
      .BC4_O(bc4), .WL_O(wl), .RL_O(rl), .RX_O(rx), .RTT_WR_O(rtt_wr), .RTT_NOM_O(rtt_nom),
      .WR_REC_O(wr_rec), .ODT_TRANS_O(trans), .ODT_ASYNC_O(async_o),
      .ODT_HOLD_ERR_O(odt_err), .TURN_ERR_O(turn_err), .MPR_ERR_O(mpr_err));
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // whole run is under 120 link periods of 8 cycles; the ceiling leaves ample room
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n, input logic o, input logic k = 1'b1);
      repeat (n) m.go(NOP, 1'b1, 3'h0, 1'b0, o, k);
   endtask
   task automatic clr;
      err_clr <= 1'b1;
      @(posedge clk);
      err_clr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic t_latency;
      al <= cl - 5'h01;
      repeat (2) @(posedge clk);
      chk(wl, 6'h09);
      chk(rl, 6'h09);
      al <= 5'h00;
      repeat (2) @(posedge clk);
      chk(wl, 6'h05);
   endtask
   task automatic t_bl8_write;
      // A12 low must not chop while the burst field is fixed
      m.go(CMD_WR, 1'b0, 3'h0, 1'b1, 1'b1, 1'b1);
      chk_bit(bc4, 1'b0);
      idle(4, 1'b1);
      chk_bit(rx, 1'b0);
      chk_bit(rtt_nom, 1'b1);
      idle(1, 1'b1);
      chk_bit(rx, 1'b1);
      chk_bit(rtt_wr, 1'b1);
      chk_bit(rtt_nom, 1'b0);
      idle(3, 1'b0);
      chk_bit(odt_err, 1'b0);
      chk_bit(rtt_wr, 1'b0);
      chk_bit(rx, 1'b1);
      idle(1, 1'b0);
      chk_bit(rx, 1'b0);
      chk_bit(wr_rec, 1'b1);
      idle(3, 1'b0);
      chk_bit(wr_rec, 1'b1);
      idle(1, 1'b0);
      chk_bit(wr_rec, 1'b0);
   endtask
   task automatic t_bc4_write;
      burst <= BURST_OTF;
      m.go(CMD_WR, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
      chk_bit(bc4, 1'b1);
      idle(3, 1'b1);
      idle(1, 1'b0);
      chk_bit(odt_err, 1'b0);
      idle(1, 1'b0);
      chk_bit(rx, 1'b1);
      idle(1, 1'b0);
      chk_bit(rx, 1'b1);
      idle(1, 1'b0);
      chk_bit(rx, 1'b0);
      m.go(CMD_WR, 1'b1, 3'h0, 1'b0, 1'b1, 1'b1);
      chk_bit(bc4, 1'b0);
      idle(3, 1'b1);
      idle(1, 1'b0);
      chk_bit(odt_err, 1'b1);
      clr();
      chk_bit(odt_err, 1'b0);
      idle(8, 1'b0);
      // chopped write with termination dropped after three clocks
      m.go(CMD_WR, 1'b0, 3'h0, 1'b0, 1'b1, 1'b1);
      idle(2, 1'b1);
      idle(1, 1'b0);
      chk_bit(odt_err, 1'b1);
      clr();
      chk_bit(odt_err, 1'b0);
      idle(8, 1'b0);
   endtask
   task automatic t_turn;
      m.go(CMD_RD, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
      idle(2, 1'b0);
      m.go(CMD_WR, 1'b1, 3'h0, 1'b0, 1'b0, 1'b1);
      chk_bit(turn_err, 1'b1);
      clr();
      chk_bit(turn_err, 1'b0);
      idle(9, 1'b0);
      m.go(CMD_RD, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
      repeat (3) m.go(DES, 1'b0, 3'h7, 1'b1, 1'b0, 1'b1);
      m.go(CMD_WR, 1'b1, 3'h0, 1'b0, 1'b0, 1'b1);
      chk_bit(turn_err, 1'b0);
      idle(9, 1'b0);
   endtask
   task automatic t_mpr;
      mpr_en <= 1'b1;
      burst <= BURST_FIX8;
      m.go(CMD_RD, 1'b1, 3'h5, 1'b0, 1'b0, 1'b1);
      chk_bit(mpr_err, 1'b1);
      clr();
      burst <= BURST_OTF;
      m.go(CMD_RD, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1);
      chk_bit(mpr_err, 1'b1);
      clr();
      m.go(CMD_RD, 1'b1, 3'h0, 1'b0, 1'b0, 1'b1);
      chk_bit(mpr_err, 1'b0);
      mpr_en <= 1'b0;
      idle(6, 1'b0);
   endtask
   task automatic t_pd;
      dll_frz <= 1'b1;
      idle(1, 1'b0, 1'b0);
      chk_bit(trans, 1'b1);
      chk_bit(async_o, 1'b0);
      idle(3, 1'b0, 1'b0);
      chk_bit(trans, 1'b1);
      idle(2, 1'b0, 1'b0);
      chk_bit(trans, 1'b0);
      chk_bit(async_o, 1'b1);
      idle(1, 1'b0);
      chk_bit(async_o, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      t_latency();
      t_bl8_write();
      t_bc4_write();
      t_turn();
      t_mpr();
      t_pd();
      results();
   end
endmodule
